// ===== shared/decoder_pkg.sv
// Constants for the binary code decoder and its APB register window.
// Assumes a 32-bit APB with byte addresses and one word per register.
package decoder_pkg;

  // ==========================================================
  // Bus geometry and register map
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h004;
  localparam logic [ADDR_W-1:0] OUT_ADDR = 12'h008;

  // ==========================================================
  // Field positions
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_INV_BIT = 1;
  localparam int CTRL_RANGE_LSB = 2;
  localparam int STAT_LOW_LSB = 0;
  localparam int STAT_UP_LSB = 3;
  localparam int STAT_BELOW_BIT = 5;
  localparam int STAT_ABOVE_BIT = 6;
  localparam int STAT_MATCH_BIT = 7;

  // ==========================================================
  // Code geometry
  localparam int MAX_IN = 5;
  localparam int LOW_BITS = 3;
  localparam int UP_BITS = 2;

  // ==========================================================
  // Modes and reset values
  typedef enum logic {
    MODE_PEAK = 1'b0,
    MODE_LEVEL = 1'b1
  } coding_mode_t;

  typedef enum logic [1:0] {
    RANGE_0_7 = 2'b00,
    RANGE_8_15 = 2'b01,
    RANGE_16_23 = 2'b10,
    RANGE_24_31 = 2'b11
  } value_range_t;

  localparam coding_mode_t MODE_RESET = MODE_PEAK;
  localparam logic INV_RESET = 1'b0;
  localparam value_range_t RANGE_RESET = RANGE_0_7;

endpackage

// ===== rtl/binary_to_onehot_decoder.sv
// Binary code decoder with one-hot or thermometer output and APB control.
// Assumes code_in comes from outside pclk's domain and APB from on-chip.
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps

module binary_to_onehot_decoder
  import decoder_pkg::*;
#(
  parameter int NUM_IN = MAX_IN,
  localparam int LOW_W = (NUM_IN < LOW_BITS) ? NUM_IN : LOW_BITS,
  localparam int NUM_OUT = 1 << LOW_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W/8-1:0] pstrb,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_IN-1:0] code_in,
  output logic [NUM_OUT-1:0] dec_out
);

  // ==========================================================
  // Build checks
  // input count bound
  if (NUM_IN < 1 || NUM_IN > MAX_IN) begin : g_bad_count
    $error("NUM_IN must lie between 1 and 5");
  end

  // ==========================================================
  // Functions
  // range legal per count
  function automatic logic range_ok(input logic [UP_BITS-1:0] r);
    logic ok;
    ok = 1'b0;
    if (r == RANGE_0_7) begin
      ok = 1'b1;
    end else if (r == RANGE_8_15) begin
      ok = (NUM_IN > LOW_BITS);
    end else begin
      ok = (NUM_IN == MAX_IN);
    end
    return ok;
  endfunction

  function automatic logic [NUM_OUT-1:0] thermo(
    input logic [LOW_BITS-1:0] v
  );
    logic [NUM_OUT-1:0] t;
    t = '0;
    for (int i = 0; i < NUM_OUT; i++) begin
      t[i] = (i <= int'(v));
    end
    return t;
  endfunction

  // ==========================================================
  // Configuration state
  coding_mode_t cfg_mode;
  logic cfg_invert;
  value_range_t cfg_range;

  // ==========================================================
  // Code input synchroniser
  // Pins are asynchronous to pclk, so two flops before any use
  logic [NUM_IN-1:0] code_meta;
  logic [NUM_IN-1:0] code_sync;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_meta <= '0;
      code_sync <= '0;
    end else begin
      code_meta <= code_in;
      code_sync <= code_meta;
    end
  end

  // ==========================================================
  // Decode path
  logic [NUM_IN-1:0] inv_code;
  logic [MAX_IN-1:0] code_full;
  logic [LOW_BITS-1:0] low_val;
  logic [UP_BITS-1:0] up_idx;
  logic range_match;
  logic range_below;
  logic range_above;
  logic [NUM_OUT-1:0] peak_pat;
  logic [NUM_OUT-1:0] level_pat;
  logic [NUM_OUT-1:0] next_dec;

  // D and E flip too, before the range compare
  // invert all together
  assign inv_code = code_sync ^ {NUM_IN{cfg_invert}};
  // Missing inputs read as zero, so fewer inputs mean fewer usable ranges
  assign code_full = MAX_IN'(inv_code);
  assign low_val = code_full[LOW_BITS-1:0];
  assign up_idx = code_full[MAX_IN-1:LOW_BITS];
  assign range_match = (up_idx == cfg_range);
  assign range_below = (up_idx < cfg_range);
  assign range_above = (up_idx > cfg_range);
  assign peak_pat = NUM_OUT'(1) << low_val;
  assign level_pat = thermo(low_val);
  assign next_dec = range_match ?
                    ((cfg_mode == MODE_LEVEL) ? level_pat : peak_pat) :
                    ((range_above && cfg_mode == MODE_LEVEL) ? '1 : '0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_out <= '0;
    end else begin
      dec_out <= next_dec;
    end
  end

  // ==========================================================
  // APB decode
  logic setup;
  logic access;
  logic hit_ctrl;
  logic hit_status;
  logic hit_out;
  logic hit_any;
  logic [UP_BITS-1:0] wr_range;
  logic wr_bad;
  logic next_err;
  logic cfg_wr;
  logic [DATA_W-1:0] ctrl_word;
  logic [DATA_W-1:0] stat_word;
  logic [DATA_W-1:0] read_mux;

  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign hit_ctrl = (paddr == CTRL_ADDR);
  assign hit_status = (paddr == STATUS_ADDR);
  assign hit_out = (paddr == OUT_ADDR);
  assign hit_any = hit_ctrl || hit_status || hit_out;
  assign wr_range = pwdata[CTRL_RANGE_LSB +: UP_BITS];
  assign wr_bad = pwrite && hit_ctrl && pstrb[0] && !range_ok(wr_range);
  // Unmapped, read-only or illegal writes all answer with an error
  // Decided at setup, so the error stands with pready
  assign next_err = setup &&
                    (!hit_any || (pwrite && !hit_ctrl) || wr_bad);
  assign cfg_wr = access && pwrite && hit_ctrl && pstrb[0] && !pslverr;

  always_comb begin
    ctrl_word = '0;
    ctrl_word[CTRL_MODE_BIT] = cfg_mode;
    ctrl_word[CTRL_INV_BIT] = cfg_invert;
    ctrl_word[CTRL_RANGE_LSB +: UP_BITS] = cfg_range;
  end

  always_comb begin
    stat_word = '0;
    stat_word[STAT_LOW_LSB +: LOW_BITS] = low_val;
    stat_word[STAT_UP_LSB +: UP_BITS] = up_idx;
    stat_word[STAT_BELOW_BIT] = range_below;
    stat_word[STAT_ABOVE_BIT] = range_above;
    stat_word[STAT_MATCH_BIT] = range_match;
  end

  assign read_mux = hit_ctrl ? ctrl_word :
                    hit_status ? stat_word :
                    hit_out ? DATA_W'(dec_out) : '0;

  // ==========================================================
  // APB answer, one access cycle with no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= setup;
      pslverr <= next_err;
      prdata <= (setup && !pwrite) ? read_mux : '0;
    end
  end

  // ==========================================================
  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_mode <= MODE_RESET;
      cfg_invert <= INV_RESET;
      cfg_range <= RANGE_RESET;
    end else if (cfg_wr) begin
      cfg_mode <= coding_mode_t'(pwdata[CTRL_MODE_BIT]);
      cfg_invert <= pwdata[CTRL_INV_BIT];
      cfg_range <= value_range_t'(wr_range);
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_PEAK_ONEHOT: assert property (
    (cfg_mode == MODE_PEAK) && range_match
    |=> $onehot(dec_out) && dec_out[$past(low_val)])
    else $error("peak output is not the single matching bit");

  AST_LEVEL_FILL: assert property (
    (cfg_mode == MODE_LEVEL) && range_match
    |=> dec_out[0] && ($countones(dec_out) == $past(low_val) + 1))
    else $error("level output does not fill up to the value");

  AST_BELOW_LOW: assert property (
    range_below |=> dec_out == '0)
    else $error("outputs not low below the range");

  AST_ABOVE_PEAK: assert property (
    range_above && (cfg_mode == MODE_PEAK) |=> dec_out == '0)
    else $error("peak outputs not low above the range");

  AST_ABOVE_LEVEL: assert property (
    range_above && (cfg_mode == MODE_LEVEL) |=> &dec_out)
    else $error("level outputs not high above the range");

  AST_INVERT_ALL: assert property (
    cfg_invert && (cfg_mode == MODE_PEAK) && (cfg_range == RANGE_0_7)
    && (&code_sync) |=> dec_out == NUM_OUT'(1))
    else $error("inverted all-ones code does not give output 1");

  AST_WEIGHT_C: assert property (
    (NUM_IN >= LOW_BITS) && !cfg_invert && (cfg_mode == MODE_PEAK)
    && (cfg_range == RANGE_0_7) && (code_sync == NUM_IN'(4))
    |=> dec_out == (NUM_OUT'(1) << 4))
    else $error("input C does not weigh four");

  AST_UPPER_COUNT: assert property (
    (NUM_IN < MAX_IN) |-> !up_idx[1] && (NUM_IN > LOW_BITS || up_idx == 0))
    else $error("upper index uses inputs that do not exist");

  AST_RANGE_LEGAL: assert property (
    range_ok(cfg_range))
    else $error("configured range not usable with this input count");

  AST_BAD_WRITE: assert property (
    access && pwrite && pslverr |=> $stable(cfg_range) && $stable(cfg_mode))
    else $error("refused write changed the configuration");

  AST_TRACK: assert property (
    $past(presetn) && $stable(code_sync) && !cfg_wr && !$past(cfg_wr)
    |=> $stable(dec_out))
    else $error("outputs changed with steady code and setting");

  AST_LEVEL_TOP: assert property (
    (cfg_mode == MODE_LEVEL) && range_match
    && (low_val == LOW_BITS'(NUM_OUT - 1)) |=> &dec_out)
    else $error("level output not full at the top value");

  AST_RANGE_INDEX: assert property (
    !cfg_invert
    && ((MAX_IN'(code_sync) >> LOW_BITS) == MAX_IN'(cfg_range))
    |-> range_match)
    else $error("upper inputs equal to the range do not match it");

  AST_REFUSE_RANGE: assert property (
    setup && pwrite && hit_ctrl && pstrb[0] && !range_ok(wr_range)
    |=> pready && pslverr)
    else $error("unusable range was not refused");

  AST_CFG_WRITE: assert property (
    cfg_wr |=> (cfg_mode == $past(pwdata[CTRL_MODE_BIT]))
    && (cfg_invert == $past(pwdata[CTRL_INV_BIT]))
    && (cfg_range == $past(wr_range)))
    else $error("accepted setting did not land");

  AST_NO_STROBE: assert property (
    access && pwrite && hit_ctrl && !pstrb[0]
    |=> $stable(cfg_mode) && $stable(cfg_invert) && $stable(cfg_range))
    else $error("write without byte 0 strobe changed the setting");

  // ==========================================================
  // Bus protocol checks
  AST_APB_ONE: assert property (
    setup |=> pready ##1 !pready)
    else $error("APB answer not exactly one cycle after setup");

  AST_READY_CAUSE: assert property (
    pready |-> $past(setup))
    else $error("APB answer without a setup cycle");

  AST_ERR_READY: assert property (
    pslverr |-> pready)
    else $error("APB error outside the answer cycle");

  AST_RDATA_IDLE: assert property (
    !pready |-> prdata == '0)
    else $error("read data not zero outside the answer cycle");

  AST_BUS_REFUSE: assert property (
    setup && (!hit_any || (pwrite && !hit_ctrl)) |=> pslverr)
    else $error("unmapped or read-only access not refused");

  AST_READ_STATUS: assert property (
    setup && !pwrite && hit_status |=> prdata == $past(stat_word))
    else $error("status read data does not match the decode");

  AST_READ_OUT: assert property (
    setup && !pwrite && hit_out |=> prdata == DATA_W'($past(dec_out)))
    else $error("output read data does not match the outputs");

  // ==========================================================
  // Covers
  COV_PEAK_MATCH: cover property (
    (cfg_mode == MODE_PEAK) && range_match && low_val != 0);
  COV_LEVEL_ABOVE: cover property (
    (cfg_mode == MODE_LEVEL) && range_above);
  COV_BAD_RANGE: cover property (access && pwrite && hit_ctrl && pslverr);
  COV_INVERT_MATCH: cover property (cfg_invert && range_match);
  COV_LEVEL_BELOW: cover property ((cfg_mode == MODE_LEVEL) && range_below);

endmodule

// ===== test/logic_source.sv
// Model of the upstream logic block that feeds the decoder's code pins.
// Assumes one pclk domain; the bench says which code to present next.
`timescale 1ns/1ps

module logic_source (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [4:0] want,
  output logic [4:0] code_in
);
  // ==========================================================
  // Code pins
  // upper bits D,E
  // Held whole between edges, so the synchroniser never sees a mix
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_in <= 5'h00;
    end else begin
      code_in <= want;
    end
  end
endmodule

// ===== test/tb_top.sv
// Self-checking bench for the binary code decoder, five and three inputs.
// Assumes the upstream logic model and APB with no wait states expected.
`timescale 1ns/1ps

module tb_top;
  import decoder_pkg::*;
  // ==========================================================
  // Signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [DATA_W-1:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [DATA_W-1:0] prdata;
  logic [DATA_W-1:0] rd;
  logic pready;
  logic pslverr;
  logic err;
  logic [4:0] want = 5'h00;
  logic [4:0] code_in;
  logic [7:0] dec_out;
  logic tgt = 1'b0;
  logic [DATA_W-1:0] prdata_s;
  logic pready_s;
  logic pslverr_s;
  logic [7:0] dec_out_s;
  wire rdy = tgt ? pready_s : pready;
  logic [31:0] rng = 32'h1;
  int n_fail = 0;
  int check_count = 0;

  always #2 pclk = ~pclk;

  binary_to_onehot_decoder #(.NUM_IN(5)) i_binary_to_onehot_decoder (
    .pclk(pclk), .presetn(presetn), .psel(psel && !tgt), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .code_in(code_in), .dec_out(dec_out)
  );

  // Three-input decoder: upper ranges must be refused
  if (1) begin : g_small
    binary_to_onehot_decoder #(.NUM_IN(3)) i_binary_to_onehot_decoder (
      .pclk(pclk), .presetn(presetn), .psel(psel && tgt), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata_s), .pready(pready_s), .pslverr(pslverr_s),
      .code_in(code_in[2:0]), .dec_out(dec_out_s)
    );
  end

  logic_source i_logic_source (
    .pclk(pclk), .presetn(presetn), .want(want), .code_in(code_in)
  );

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [7:0] expect_dec(input logic [4:0] c,
      input logic [3:0] cfg);
    logic [4:0] v;
    logic [7:0] r;
    v = cfg[1] ? ~c : c;
    if (v[4:3] < cfg[3:2]) r = 8'h00;
    else if (v[4:3] > cfg[3:2]) r = cfg[0] ? 8'hff : 8'h00;
    else if (cfg[0]) r = (8'h02 << v[2:0]) - 8'h01;
    else r = 8'h01 << v[2:0];
    return r;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      n_fail++;
    end
  endtask

  // Holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int i;
    i = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      i++;
    end while (rdy !== 1'b1 && i < 50);
    if (rdy !== 1'b1) begin
      $display("unexpected at %0t: got %h exp %h", $time, rdy, 1'b1);
      n_fail++;
    end
    rd = tgt ? prdata_s : prdata;
    err = tgt ? pslverr_s : pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Three edges pin to output, plus one for the source register
  task automatic set_code(input logic [4:0] c);
    @(posedge pclk);
    want <= c;
    repeat (4) @(posedge pclk);
    #1;
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial begin
    logic [4:0] c;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
    chk({24'h0, dec_out}, 32'h1);
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk(rd, 32'h0);
    $display("test reset done");
    // Every mode, inversion and range; each upper index first, then random
    for (int cfg = 0; cfg < 16; cfg++) begin
      apb(1'b1, CTRL_ADDR, cfg);
      for (int k = 0; k < 8; k++) begin
        rng = xorshift(rng);
        c = (k < 4) ? {k[1:0], rng[2:0]} : rng[4:0];
        set_code(c);
        chk({24'h0, dec_out}, expect_dec(c, cfg[3:0]));
        apb(1'b0, OUT_ADDR, 32'h0);
        chk(rd, {24'h0, expect_dec(c, cfg[3:0])});
      end
    end
    $display("test sweep done");
    // Refused and ignored writes leave the setting alone
    apb(1'b1, CTRL_ADDR, 32'h1);
    pstrb <= 4'h0;
    apb(1'b1, CTRL_ADDR, 32'hc);
    pstrb <= 4'hf;
    chk({31'h0, err}, 32'h0);
    apb(1'b1, STATUS_ADDR, 32'hc);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 12'h00c, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk(rd, 32'h1);
    set_code(5'h1f);
    chk({24'h0, dec_out}, {24'h0, expect_dec(5'h1f, 4'h1)});
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk(rd, 32'h5f);
    $display("test refusal done");
    // Three inputs: upper ranges refused, missing bits read low
    @(posedge pclk);
    tgt <= 1'b1;
    apb(1'b1, CTRL_ADDR, 32'h5);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, CTRL_ADDR, 32'h8);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, CTRL_ADDR, 32'h3);
    chk({31'h0, err}, 32'h0);
    for (int k = 0; k < 8; k++) begin
      rng = xorshift(rng);
      c = (k == 0) ? 5'h1f : rng[4:0];
      set_code(c);
      chk({24'h0, dec_out_s}, expect_dec({2'b00, ~c[2:0]}, 4'h1));
    end
    $display("test small done");
    conclude;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    conclude;
  end
endmodule
